/* File: logic/odm_defines.vh */
// Behaviour
// - Break on flow change and single step
// - Four resources split program/data as configured
// - Two resources form one masked range point
// - Debugger injects instructions, device executes them
// - CPU returns results through mailbox I/O location
// - Debug needs both fuses, no lock bit
// - Any lock bit forces debug off
// - Opcodes 0x8 to 0xB are debug instructions
// - CPU mailbox write stores byte, sets dirty
// - Mailbox read gives seven bits plus dirty
// - Debugger clears dirty after reading mailbox
// - Mailbox reachable only with fuse and enable
// - Otherwise shared address hits ordinary register
// - Programming needs port fuse, disable bit clear
// - Programming covers flash, EEPROM, fuses, locks
// - Locked part refuses debug fuse until erase
// - Four-bit instructions shifted in LSB first
// - Instruction capture shifts out 0x01
`ifndef ODM_DEFINES_VH
`define ODM_DEFINES_VH

// ****************************************
// Instruction register
// ****************************************
`define ODM_IR_W 4
`define ODM_IR_CAPTURE 4'h1
`define ODM_IR_RESET 4'h1
`define ODM_OP_DBG0 4'h8
`define ODM_OP_DBG1 4'h9
`define ODM_OP_DBG2 4'hA
`define ODM_OP_DBG3 4'hB

// ****************************************
// Data register selection and lengths
// ****************************************
`define ODM_SEL_BYP 3'h0
`define ODM_SEL_MBOX 3'h1
`define ODM_SEL_BPCFG 3'h2
`define ODM_SEL_CTRL 3'h3
`define ODM_SEL_INJ 3'h4
`define ODM_DR_W 24
`define ODM_LEN_BYP 5'h01
`define ODM_LEN_MBOX 5'h09
`define ODM_LEN_BPCFG 5'h18
`define ODM_LEN_CTRL 5'h08
`define ODM_LEN_INJ 5'h10

// ****************************************
// Data register fields
// ****************************************
`define ODM_MBOX_CLR_BIT 8
`define ODM_BP_IDX_LSB 16
`define ODM_BP_EN_BIT 18
`define ODM_BP_MODE_LSB 19
`define ODM_BP_MODE_WR_BIT 22
`define ODM_CTRL_ACC_BIT 0
`define ODM_CTRL_STEP_BIT 1
`define ODM_CTRL_FLOW_BIT 2
`define ODM_CTRL_CLRHIT_BIT 3

// ****************************************
// Break point modes
// ****************************************
`define ODM_MODE_4P 3'h0
`define ODM_MODE_3P1D 3'h1
`define ODM_MODE_2P2D 3'h2
`define ODM_MODE_RNGP 3'h3
`define ODM_MODE_RNGD 3'h4

// ****************************************
// CPU side addresses and reset values
// ****************************************
`define ODM_MBOX_ADDR 6'h31
`define ODM_STD_RESET 8'h00
`define ODM_MBOX_RESET 8'h00

`endif

/* File: logic/odm_sync.v */
`timescale 1ns/1ns
module odm_sync #(
	parameter W = 3
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

reg [W-1:0] meta_r;

always @(posedge clk)
begin
	if (rst)
	begin
		meta_r <= {W{1'b0}};
		q <= {W{1'b0}};
	end
	else
	begin
		meta_r <= d;
		q <= meta_r;
	end
end

endmodule

/* File: logic/odm_bpcmp.v */
`timescale 1ns/1ns
module odm_bpcmp #(
	parameter AW = 16
) (
	input wire en,
	input wire valid,
	input wire [AW-1:0] addr,
	input wire [AW-1:0] value,
	input wire [AW-1:0] mask,
	output wire hit
);

// Only bits with a one in the mask take part in the compare
assign hit = en & valid & (((addr ^ value) & mask) == {AW{1'b0}});

endmodule

/* File: logic/odm_top.v */
`timescale 1ns/1ns
`include "odm_defines.vh"
module odm_top #(
	parameter AW = 16,
	parameter [5:0] MBOX_ADDR = `ODM_MBOX_ADDR
) (
	input wire CLK,
	input wire SYS_RST,
	input wire TCK,
	input wire TMS,
	input wire TDI,
	output reg TDO,
	output reg TDO_OE_N,
	input wire FUSE_TP_EN,
	input wire FUSE_DBG_EN,
	input wire LOCK_BIT_ONE,
	input wire LOCK_BIT_TWO,
	input wire TEST_PORT_DISABLE,
	input wire [5:0] IO_ADDR,
	input wire IO_WE,
	input wire IO_RE,
	input wire [7:0] IO_WDATA,
	output reg [7:0] IO_RDATA,
	input wire [AW-1:0] PC,
	input wire PC_VALID,
	input wire [AW-1:0] DATA_ADDR,
	input wire DATA_VALID,
	input wire FLOW_CHANGE,
	output reg CPU_BREAK,
	output reg INJ_VALID,
	output reg [15:0] INJ_INSTR,
	output reg DEBUG_ACTIVE,
	output reg PROG_ENABLE,
	input wire FUSE_PROG_REQ,
	input wire CHIP_ERASE_DONE,
	output reg FUSE_PROG_GRANT,
	output reg FUSE_PROG_DENY
);

// ****************************************
// TAP states
// ****************************************
localparam S_TLR = 4'h0;
localparam S_RTI = 4'h1;
localparam S_SELDR = 4'h2;
localparam S_CAPDR = 4'h3;
localparam S_SHDR = 4'h4;
localparam S_EX1DR = 4'h5;
localparam S_PADR = 4'h6;
localparam S_EX2DR = 4'h7;
localparam S_UPDR = 4'h8;
localparam S_SELIR = 4'h9;
localparam S_CAPIR = 4'hA;
localparam S_SHIR = 4'hB;
localparam S_EX1IR = 4'hC;
localparam S_PAIR = 4'hD;
localparam S_EX2IR = 4'hE;
localparam S_UPIR = 4'hF;

// ****************************************
// Decode functions
// ****************************************
function [2:0] odm_sel;
	input [3:0] ir;
	input dbg;
	begin
		odm_sel = `ODM_SEL_BYP;
		// Private opcodes
		// decode debug opcodes
		if (dbg)
		begin
			case (ir)
				`ODM_OP_DBG0: odm_sel = `ODM_SEL_MBOX;
				`ODM_OP_DBG1: odm_sel = `ODM_SEL_BPCFG;
				`ODM_OP_DBG2: odm_sel = `ODM_SEL_CTRL;
				`ODM_OP_DBG3: odm_sel = `ODM_SEL_INJ;
				default: odm_sel = `ODM_SEL_BYP;
			endcase
		end
	end
endfunction

function [4:0] odm_len;
	input [2:0] sel;
	begin
		case (sel)
			`ODM_SEL_MBOX: odm_len = `ODM_LEN_MBOX;
			`ODM_SEL_BPCFG: odm_len = `ODM_LEN_BPCFG;
			`ODM_SEL_CTRL: odm_len = `ODM_LEN_CTRL;
			`ODM_SEL_INJ: odm_len = `ODM_LEN_INJ;
			default: odm_len = `ODM_LEN_BYP;
		endcase
	end
endfunction

function odm_isdata;
	input [2:0] mode;
	input integer idx;
	begin
		case (mode)
			`ODM_MODE_3P1D: odm_isdata = (idx == 3);
			`ODM_MODE_2P2D: odm_isdata = (idx >= 2);
			`ODM_MODE_RNGD: odm_isdata = (idx == 2);
			default: odm_isdata = 1'b0;
		endcase
	end
endfunction

// ****************************************
// Pin sampling
// ****************************************
wire [2:0] pin_s;
wire tck_s = pin_s[2];
wire tms_s = pin_s[1];
wire tdi_s = pin_s[0];
reg tck_d_r;

odm_sync #(
	.W(3)
) u_sync (
	.clk(CLK),
	.rst(SYS_RST),
	.d({TCK, TMS, TDI}),
	.q(pin_s)
);

wire tck_rise = tck_s & ~tck_d_r;
wire tck_fall = ~tck_s & tck_d_r;

// ****************************************
// Enables
// ****************************************
// port enable gating
wire tap_en = FUSE_TP_EN & ~TEST_PORT_DISABLE;
wire dbg_en = tap_en & FUSE_DBG_EN & ~LOCK_BIT_ONE & ~LOCK_BIT_TWO;

// ****************************************
// TAP controller
// ****************************************
reg [3:0] tap_st_r;
reg [3:0] tap_st_nxt;
reg [3:0] ir_sh_r;
reg [3:0] ir_r;
reg [`ODM_DR_W-1:0] dr_sh_r;
reg [`ODM_DR_W-1:0] dr_shift_nxt;
reg [`ODM_DR_W-1:0] dr_cap;
integer len_m1;
integer i;
reg [7:0] mbox_r;
reg dirty_r;
reg acc_en_r;
reg step_en_r;
reg flow_en_r;
reg hit_r;
reg [3:0] bp_en_r;
reg [2:0] bp_mode_r;
wire brk_nxt;

wire [2:0] sel = odm_sel(ir_r, dbg_en);
wire [4:0] dr_len = odm_len(sel);
wire upd_dr = tck_rise & (tap_st_r == S_UPDR);
wire [24:0] dr_ext = {1'b0, dr_sh_r};

always @*
begin
	case (tap_st_r)
		S_TLR: tap_st_nxt = tms_s ? S_TLR : S_RTI;
		S_RTI: tap_st_nxt = tms_s ? S_SELDR : S_RTI;
		S_SELDR: tap_st_nxt = tms_s ? S_SELIR : S_CAPDR;
		S_CAPDR: tap_st_nxt = tms_s ? S_EX1DR : S_SHDR;
		S_SHDR: tap_st_nxt = tms_s ? S_EX1DR : S_SHDR;
		S_EX1DR: tap_st_nxt = tms_s ? S_UPDR : S_PADR;
		S_PADR: tap_st_nxt = tms_s ? S_EX2DR : S_PADR;
		S_EX2DR: tap_st_nxt = tms_s ? S_UPDR : S_SHDR;
		S_UPDR: tap_st_nxt = tms_s ? S_SELDR : S_RTI;
		S_SELIR: tap_st_nxt = tms_s ? S_TLR : S_CAPIR;
		S_CAPIR: tap_st_nxt = tms_s ? S_EX1IR : S_SHIR;
		S_SHIR: tap_st_nxt = tms_s ? S_EX1IR : S_SHIR;
		S_EX1IR: tap_st_nxt = tms_s ? S_UPIR : S_PAIR;
		S_PAIR: tap_st_nxt = tms_s ? S_EX2IR : S_PAIR;
		S_EX2IR: tap_st_nxt = tms_s ? S_UPIR : S_SHIR;
		S_UPIR: tap_st_nxt = tms_s ? S_SELDR : S_RTI;
		default: tap_st_nxt = S_TLR;
	endcase
end

// Capture values for the selected data register
always @*
begin
	case (sel)
		`ODM_SEL_MBOX: dr_cap = {15'h0000, dirty_r, mbox_r};
		`ODM_SEL_BPCFG: dr_cap = {2'h0, bp_mode_r, bp_en_r, 15'h0000};
		`ODM_SEL_CTRL: dr_cap = {20'h0_0000, hit_r, flow_en_r,
			step_en_r, acc_en_r};
		`ODM_SEL_INJ: dr_cap = {16'h0000, mbox_r};
		default: dr_cap = {`ODM_DR_W{1'b0}};
	endcase
end

// TDI enters at the top of the active length, LSB leaves first
always @*
begin
	len_m1 = dr_len - 1;
	for (i = 0; i < `ODM_DR_W; i = i + 1)
	begin
		if (i == len_m1)
			dr_shift_nxt[i] = tdi_s;
		else if (i < len_m1)
			dr_shift_nxt[i] = dr_ext[i+1];
		else
			dr_shift_nxt[i] = 1'b0;
	end
end

always @(posedge CLK)
begin
	if (SYS_RST)
	begin
		tck_d_r <= 1'b0;
		tap_st_r <= S_TLR;
		ir_sh_r <= `ODM_IR_RESET;
		ir_r <= `ODM_IR_RESET;
		dr_sh_r <= {`ODM_DR_W{1'b0}};
		TDO <= 1'b0;
		TDO_OE_N <= 1'b1;
	end
	else
	begin
		tck_d_r <= tck_s;
		// Port held in reset while disabled, pins stay released
		if (!tap_en)
		begin
			tap_st_r <= S_TLR;
			ir_r <= `ODM_IR_RESET;
			TDO_OE_N <= 1'b1;
		end
		else
		begin
			if (tck_rise)
			begin
				tap_st_r <= tap_st_nxt;
				case (tap_st_r)
					S_TLR: ir_r <= `ODM_IR_RESET;
					S_CAPIR: ir_sh_r <= `ODM_IR_CAPTURE;
					S_SHIR: ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
					S_UPIR: ir_r <= ir_sh_r;
					S_CAPDR: dr_sh_r <= dr_cap;
					S_SHDR: dr_sh_r <= dr_shift_nxt;
					default: ir_r <= ir_r;
				endcase
			end
			// Output changes on the falling test clock edge
			if (tck_fall)
			begin
				TDO <= (tap_st_r == S_SHIR) ? ir_sh_r[0] :
					(tap_st_r == S_SHDR) ? dr_sh_r[0] : 1'b0;
				TDO_OE_N <= ~((tap_st_r == S_SHIR) |
					(tap_st_r == S_SHDR));
			end
		end
	end
end

// ****************************************
// Mailbox and shared I/O location
// ****************************************
reg [7:0] std_r;

wire mbox_hit = (IO_ADDR == MBOX_ADDR);
wire mbox_acc = FUSE_DBG_EN & acc_en_r;
wire cpu_mbox_wr = IO_WE & mbox_hit & mbox_acc;
wire mbox_clr = upd_dr & (sel == `ODM_SEL_MBOX) &
	dr_sh_r[`ODM_MBOX_CLR_BIT];
wire ctrl_upd = upd_dr & (sel == `ODM_SEL_CTRL);

always @(posedge CLK)
begin
	if (SYS_RST)
	begin
		mbox_r <= `ODM_MBOX_RESET;
		dirty_r <= 1'b0;
		std_r <= `ODM_STD_RESET;
		IO_RDATA <= 8'h00;
	end
	else
	begin
		if (cpu_mbox_wr)
			mbox_r <= IO_WDATA;
		// A CPU write in the clearing cycle keeps the flag set
		if (cpu_mbox_wr)
			dirty_r <= 1'b1;
		else if (mbox_clr)
			dirty_r <= 1'b0;
		if (IO_WE & mbox_hit & ~mbox_acc)
			std_r <= IO_WDATA;
		if (IO_RE & mbox_hit)
			IO_RDATA <= mbox_acc ? {dirty_r, mbox_r[6:0]} : std_r;
		else
			IO_RDATA <= 8'h00;
	end
end

// ****************************************
// Debug control
// ****************************************
always @(posedge CLK)
begin
	if (SYS_RST)
	begin
		acc_en_r <= 1'b0;
		step_en_r <= 1'b0;
		flow_en_r <= 1'b0;
		hit_r <= 1'b0;
	end
	else if (!dbg_en)
	begin
		acc_en_r <= 1'b0;
		step_en_r <= 1'b0;
		flow_en_r <= 1'b0;
		hit_r <= 1'b0;
	end
	else
	begin
		if (ctrl_upd)
		begin
			acc_en_r <= dr_sh_r[`ODM_CTRL_ACC_BIT];
			step_en_r <= dr_sh_r[`ODM_CTRL_STEP_BIT];
			flow_en_r <= dr_sh_r[`ODM_CTRL_FLOW_BIT];
		end
		if (brk_nxt)
			hit_r <= 1'b1;
		else if (ctrl_upd & dr_sh_r[`ODM_CTRL_CLRHIT_BIT])
			hit_r <= 1'b0;
	end
end

// ****************************************
// Break point unit
// ****************************************
reg [AW-1:0] bp_val_r [0:3];
wire [3:0] bp_hit;
wire [1:0] bp_idx = dr_sh_r[`ODM_BP_IDX_LSB+1:`ODM_BP_IDX_LSB];
wire bp_upd = upd_dr & (sel == `ODM_SEL_BPCFG);
wire rng = (bp_mode_r == `ODM_MODE_RNGP) | (bp_mode_r == `ODM_MODE_RNGD);

genvar g;
generate
	for (g = 0; g < 4; g = g + 1)
	begin : g_bp
		wire is_data = odm_isdata(bp_mode_r, g);
		// range uses next value as mask
		wire [AW-1:0] msk = (g == 2 && rng) ? bp_val_r[3] : {AW{1'b1}};
		wire en = bp_en_r[g] & ~(g == 3 && rng);
		odm_bpcmp #(
			.AW(AW)
		) u_cmp (
			.en(en),
			.valid(is_data ? DATA_VALID : PC_VALID),
			.addr(is_data ? DATA_ADDR : PC),
			.value(bp_val_r[g]),
			.mask(msk),
			.hit(bp_hit[g])
		);
	end
endgenerate

assign brk_nxt = dbg_en & ((|bp_hit) | (step_en_r & PC_VALID) |
	(flow_en_r & FLOW_CHANGE));

always @(posedge CLK)
begin
	if (SYS_RST)
	begin
		bp_en_r <= 4'h0;
		bp_mode_r <= `ODM_MODE_4P;
		bp_val_r[0] <= {AW{1'b0}};
		bp_val_r[1] <= {AW{1'b0}};
		bp_val_r[2] <= {AW{1'b0}};
		bp_val_r[3] <= {AW{1'b0}};
		CPU_BREAK <= 1'b0;
	end
	else
	begin
		CPU_BREAK <= brk_nxt;
		if (!dbg_en)
			bp_en_r <= 4'h0;
		else if (bp_upd)
		begin
			bp_val_r[bp_idx] <= dr_sh_r[AW-1:0];
			bp_en_r[bp_idx] <= dr_sh_r[`ODM_BP_EN_BIT];
			if (dr_sh_r[`ODM_BP_MODE_WR_BIT])
				bp_mode_r <= dr_sh_r[`ODM_BP_MODE_LSB+2:`ODM_BP_MODE_LSB];
		end
	end
end

// ****************************************
// Instruction injection and programming
// ****************************************
reg erase_seen_r;
wire locked = LOCK_BIT_ONE | LOCK_BIT_TWO;

always @(posedge CLK)
begin
	if (SYS_RST)
	begin
		INJ_VALID <= 1'b0;
		INJ_INSTR <= 16'h0000;
		DEBUG_ACTIVE <= 1'b0;
		PROG_ENABLE <= 1'b0;
		erase_seen_r <= 1'b0;
		FUSE_PROG_GRANT <= 1'b0;
		FUSE_PROG_DENY <= 1'b0;
	end
	else
	begin
		INJ_VALID <= upd_dr & (sel == `ODM_SEL_INJ);
		if (upd_dr & (sel == `ODM_SEL_INJ))
			INJ_INSTR <= dr_sh_r[15:0];
		DEBUG_ACTIVE <= dbg_en;
		PROG_ENABLE <= tap_en;
		if (CHIP_ERASE_DONE)
			erase_seen_r <= 1'b1;
		FUSE_PROG_GRANT <= FUSE_PROG_REQ & tap_en &
			(~locked | erase_seen_r | CHIP_ERASE_DONE);
		FUSE_PROG_DENY <= FUSE_PROG_REQ &
			~(tap_en & (~locked | erase_seen_r | CHIP_ERASE_DONE));
	end
end

endmodule

/* File: dv/odm_checker.sv */
`timescale 1ns/1ns
`include "odm_defines.vh"
module odm_checker #(
	parameter [5:0] MBOX_ADDR = `ODM_MBOX_ADDR
) (
	input wire CLK,
	input wire SYS_RST,
	input wire FUSE_TP_EN,
	input wire FUSE_DBG_EN,
	input wire LOCK_BIT_ONE,
	input wire LOCK_BIT_TWO,
	input wire TEST_PORT_DISABLE,
	input wire [5:0] IO_ADDR,
	input wire IO_WE,
	input wire IO_RE,
	input wire [7:0] IO_WDATA,
	input wire [7:0] IO_RDATA,
	input wire PC_VALID,
	input wire DATA_VALID,
	input wire FLOW_CHANGE,
	input wire CPU_BREAK,
	input wire INJ_VALID,
	input wire DEBUG_ACTIVE,
	input wire PROG_ENABLE,
	input wire FUSE_PROG_REQ,
	input wire CHIP_ERASE_DONE,
	input wire FUSE_PROG_GRANT,
	input wire FUSE_PROG_DENY
);
	// ********
	// Checks
	// ********
	reg [7:0] wd_p;
	reg erase_seen;
	wire mb_wr = IO_WE && IO_ADDR == MBOX_ADDR;
	wire mb_rd = IO_RE && IO_ADDR == MBOX_ADDR;
	wire locked = LOCK_BIT_ONE || LOCK_BIT_TWO;
	wire tap_en = FUSE_TP_EN && !TEST_PORT_DISABLE;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	always @(posedge CLK)
	begin
		if (mb_wr)
			wd_p <= IO_WDATA;
		erase_seen <= !SYS_RST && (erase_seen || CHIP_ERASE_DONE);
	end
	a_mbox_low_bits: assert property (mb_wr ##1 mb_rd |=>
		IO_RDATA[6:0] == wd_p[6:0]) else $error("mailbox low bits");
	a_prog_level: assert property (!$past(SYS_RST) |->
		PROG_ENABLE == $past(tap_en)) else $error("prog enable level");
	a_debug_level: assert property (!$past(SYS_RST) |->
		DEBUG_ACTIVE == ($past(tap_en) && $past(FUSE_DBG_EN)
		&& !$past(locked))) else $error("debug active level");
	a_lock_off: assert property (locked |=> !DEBUG_ACTIVE)
		else $error("debug active while locked");
	a_fuse_answer: assert property (FUSE_PROG_REQ |=>
		FUSE_PROG_GRANT ^ FUSE_PROG_DENY) else $error("fuse answer");
	a_fuse_deny: assert property (FUSE_PROG_REQ && locked
		&& !erase_seen && !CHIP_ERASE_DONE |=> FUSE_PROG_DENY)
		else $error("locked fuse not refused");
	a_break_cause: assert property (CPU_BREAK |-> $past(PC_VALID)
		|| $past(DATA_VALID) || $past(FLOW_CHANGE))
		else $error("break without cause");
	a_inj_single: assert property (INJ_VALID |=> !INJ_VALID)
		else $error("inject pulse too long");
endmodule
bind odm_top odm_checker #(.MBOX_ADDR(MBOX_ADDR)) odm_checker_i (
	.CLK(CLK), .SYS_RST(SYS_RST), .FUSE_TP_EN(FUSE_TP_EN),
	.FUSE_DBG_EN(FUSE_DBG_EN), .LOCK_BIT_ONE(LOCK_BIT_ONE),
	.LOCK_BIT_TWO(LOCK_BIT_TWO), .TEST_PORT_DISABLE(TEST_PORT_DISABLE),
	.IO_ADDR(IO_ADDR), .IO_WE(IO_WE), .IO_RE(IO_RE),
	.IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .PC_VALID(PC_VALID),
	.DATA_VALID(DATA_VALID), .FLOW_CHANGE(FLOW_CHANGE),
	.CPU_BREAK(CPU_BREAK), .INJ_VALID(INJ_VALID),
	.DEBUG_ACTIVE(DEBUG_ACTIVE), .PROG_ENABLE(PROG_ENABLE),
	.FUSE_PROG_REQ(FUSE_PROG_REQ), .CHIP_ERASE_DONE(CHIP_ERASE_DONE),
	.FUSE_PROG_GRANT(FUSE_PROG_GRANT), .FUSE_PROG_DENY(FUSE_PROG_DENY)
);

/* File: dv/odm_dbg_model.sv */
`timescale 1ns/1ns
module odm_dbg_model (
	input wire clk,
	output reg tck,
	output reg tms,
	output reg tdi,
	input wire tdo
);
	// ********
	// Debugger pins
	// ********
	// Idle pins sit at the pulled-up level, test clock stands still
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	task tick(input m, input d, output o);
	begin
		tms <= m;
		tdi <= d;
		repeat (8) @(posedge clk);
		tck <= 1'b1;
		o = tdo;
		repeat (8) @(posedge clk);
		tck <= 1'b0;
	end
	endtask
	task tap_reset;
		integer i;
		reg t;
	begin
		for (i = 0; i < 5; i = i + 1)
			tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
	end
	endtask
	task scan(input ir, input [23:0] din, input integer n,
		output [23:0] dout);
		integer i;
		reg t;
	begin
		dout = 24'h00_0000;
		tick(1'b1, 1'b1, t);
		if (ir)
			tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
		tick(1'b0, 1'b1, t);
		for (i = 0; i < n; i = i + 1)
		begin
			tick(i == n - 1, din[i], t);
			dout[i] = t;
		end
		tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
		@(posedge clk);
		tms <= 1'b1;
		tdi <= 1'b1;
	end
	endtask
endmodule

/* File: dv/odm_tb.sv */
`timescale 1ns/1ns
`include "odm_defines.vh"
module testbench;
	// ********
	// Bench
	// ********
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg dbg_en = 1'b1;
	reg lk1 = 1'b0;
	reg lk2 = 1'b0;
	reg tp_dis = 1'b0;
	reg we = 1'b0;
	reg re = 1'b0;
	reg pcv = 1'b0;
	reg dv = 1'b0;
	reg [15:0] da = 16'h0000;
	reg flow = 1'b0;
	reg freq = 1'b0;
	reg erase = 1'b0;
	reg [5:0] addr = 6'h00;
	reg [7:0] wd = 8'h00;
	reg [15:0] pc = 16'h0000;
	reg [15:0] inj_seen = 16'h0000;
	reg [23:0] v;
	reg [7:0] b;
	reg [2:0] o;
	integer errors = 0;
	integer compares = 0;
	wire tck, tms, tdi, tdo, oe_n, brk, injv, act, pen, grant, deny;
	wire [7:0] rd;
	wire [15:0] inj;
	// TDO floats outside shifts; the board pull-up sets its level
	wire tdo_w = oe_n ? 1'b1 : tdo;
	always #5 clk = ~clk;
	odm_top odm_top_i (
		.CLK(clk), .SYS_RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
		.TDO(tdo), .TDO_OE_N(oe_n), .FUSE_TP_EN(1'b1),
		.FUSE_DBG_EN(dbg_en), .LOCK_BIT_ONE(lk1), .LOCK_BIT_TWO(lk2),
		.TEST_PORT_DISABLE(tp_dis), .IO_ADDR(addr), .IO_WE(we),
		.IO_RE(re), .IO_WDATA(wd), .IO_RDATA(rd), .PC(pc),
		.PC_VALID(pcv), .DATA_ADDR(da), .DATA_VALID(dv),
		.FLOW_CHANGE(flow), .CPU_BREAK(brk), .INJ_VALID(injv),
		.INJ_INSTR(inj), .DEBUG_ACTIVE(act), .PROG_ENABLE(pen),
		.FUSE_PROG_REQ(freq), .CHIP_ERASE_DONE(erase),
		.FUSE_PROG_GRANT(grant), .FUSE_PROG_DENY(deny)
	);
	odm_dbg_model odm_dbg_model_i (
		.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w)
	);
	always @(posedge clk)
		if (injv)
			inj_seen <= inj;
	task chk(input string nm, input [23:0] e, input [23:0] g);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("Error %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task io_wr(input [5:0] a, input [7:0] d);
	begin
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	end
	endtask
	task io_rd(input [5:0] a);
	begin
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		b = rd;
		@(posedge clk);
	end
	endtask
	task step(input [4:0] s);
	begin
		{dv, pcv, flow, freq, erase} <= s;
		@(posedge clk);
		{dv, pcv, flow, freq, erase} <= 5'h00;
		#1;
		o = {brk, grant, deny};
		@(posedge clk);
	end
	endtask
	task sc(input i, input [23:0] d, input integer n);
	begin
		odm_dbg_model_i.scan(i, d, n, v);
	end
	endtask
	task tally_and_finish;
	begin
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// ********
	// Sequence
	// ********
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("active", 1, act);
		odm_dbg_model_i.tap_reset;
		sc(1, `ODM_OP_DBG2, 4);
		chk("ir", `ODM_IR_CAPTURE, v);
		sc(0, 24'h1, 8);
		io_wr(`ODM_MBOX_ADDR, 8'h5A);
		io_rd(`ODM_MBOX_ADDR);
		chk("mbox", 8'hDA, b);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		odm_dbg_model_i.tap_reset;
		sc(1, `ODM_OP_DBG0, 4);
		sc(0, 24'h0, 9);
		chk("rst_dirty", 24'h0, v);
		chk("oe_idle", 1'b1, oe_n);
		sc(1, `ODM_OP_DBG2, 4);
		sc(0, 24'h1, 8);
		io_wr(`ODM_MBOX_ADDR, 8'h5A);
		sc(1, `ODM_OP_DBG0, 4);
		sc(0, 24'h100, 9);
		chk("mbox_scan", 24'h15A, v);
		io_rd(`ODM_MBOX_ADDR);
		chk("mbox_clr", 8'h5A, b);
		io_rd(6'h30);
		chk("unmapped", 8'h00, b);
		sc(1, `ODM_OP_DBG3, 4);
		sc(0, 24'h9512, 16);
		chk("inj_cap", 24'h5A, v);
		chk("inj", 16'h9512, inj_seen);
		sc(1, `ODM_OP_DBG1, 4);
		sc(0, 24'h44_1234, 24);
		pc <= 16'h1234;
		step(4'h8);
		chk("bp_hit", 3'h4, o);
		pc <= 16'h1235;
		step(4'h8);
		chk("bp_miss", 3'h0, o);
		sc(0, 24'h5E_1200, 24);
		sc(0, 24'h5B_FF00, 24);
		sc(0, 24'h0, 24);
		chk("bp_cfg", 24'h1A_8000, v);
		pc <= 16'h12AB;
		step(4'h8);
		chk("rng_hit", 3'h4, o);
		pc <= 16'h13AB;
		step(4'h8);
		chk("rng_miss", 3'h0, o);
		sc(0, 24'h66_1200, 24);
		da <= 16'h12AB;
		step(5'h10);
		chk("rngd_hit", 3'h4, o);
		sc(0, 24'h57_0040, 24);
		da <= 16'h0040;
		step(5'h10);
		chk("dbp_hit", 3'h4, o);
		pc <= 16'h0040;
		step(5'h08);
		chk("dbp_pc", 3'h0, o);
		sc(0, 24'h48_0000, 24);
		pc <= 16'h1200;
		step(5'h08);
		chk("p3d1", 3'h4, o);
		sc(1, `ODM_OP_DBG2, 4);
		sc(0, 24'h6, 8);
		chk("ctrl", 24'h9, v);
		step(4'h4);
		chk("flow", 3'h4, o);
		step(4'h8);
		chk("single", 3'h4, o);
		io_wr(`ODM_MBOX_ADDR, 8'h33);
		io_rd(`ODM_MBOX_ADDR);
		chk("plain_reg", 8'h33, b);
		lk1 <= 1'b1;
		step(4'h2);
		chk("deny", 3'h1, o);
		chk("lock1", 0, act);
		step(4'h1);
		step(4'h2);
		chk("grant", 3'h2, o);
		{lk1, lk2} <= 2'b01;
		step(4'h0);
		chk("lock2", 0, act);
		{lk2, dbg_en, tp_dis} <= 3'b001;
		repeat (4) @(posedge clk);
		chk("prog_off", 0, pen);
		tp_dis <= 1'b0;
		step(4'h0);
		chk("prog_on", 1, pen);
		chk("fuse_off", 0, act);
		odm_dbg_model_i.tap_reset;
		sc(1, `ODM_OP_DBG0, 4);
		sc(0, 24'h1FF, 9);
		chk("dbg_off", 24'h1FE, v);
		tally_and_finish;
	end
endmodule
